// File: pkg/bcr_pkg.sv
package bcr_pkg;
    // ==========================================
    // register offsets, low byte of the window
    localparam logic [7:0] OFS_VME_DATA_LOW = 8'h00;
    localparam logic [7:0] OFS_VME_DATA_HIGH = 8'h02;
    localparam logic [7:0] OFS_VME_ADDRESS_LOW = 8'h04;
    localparam logic [7:0] OFS_VME_ADDRESS_HIGH = 8'h06;
    localparam logic [7:0] OFS_VME_STATUS_A = 8'h08;
    localparam logic [7:0] OFS_VME_STATUS_B = 8'h0A;
    localparam logic [7:0] OFS_BURST_COUNT = 8'h0C;
    localparam logic [7:0] OFS_CYCLE_TIME = 8'h0E;
    localparam logic [7:0] OFS_VSB_DATA_LOW = 8'h10;
    localparam logic [7:0] OFS_VSB_DATA_HIGH = 8'h12;
    localparam logic [7:0] OFS_VSB_ADDRESS_LOW = 8'h14;
    localparam logic [7:0] OFS_VSB_ADDRESS_HIGH = 8'h16;
    localparam logic [7:0] OFS_VSB_STATUS_A = 8'h18;
    localparam logic [7:0] OFS_VSB_STATUS_B = 8'h1A;
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'h1C;
    localparam logic [7:0] OFS_JUMPER_READBACK = 8'h1E;
    // ==========================================
    // control word fields
    localparam int CTL_RW_LSB = 4;
    localparam int CTL_FREE_RUN_BIT = 7;
    localparam int CTL_MODE_LSB = 8;
    localparam int CTL_SRC_SEL_BIT = 10;
    localparam int CTL_SRESET_BIT = 11;
    localparam int CTL_DELAY_LSB = 12;
    localparam logic [3:0] CTL_RW_RST = 4'h0;
    localparam logic [3:0] CTL_DELAY_RST = 4'h0;
    // ==========================================
    // short i/o address modifiers
    localparam logic [5:0] AM_SHORT_SUPER = 6'h2D;
    localparam logic [5:0] AM_SHORT_USER = 6'h29;
    // ==========================================
    // timing
    localparam int CLK_KHZ = 10000;
    localparam int CLK_PERIOD_PS = 100000;
    localparam int STRETCH_MS = 350;
    localparam int STRETCH_CYC = STRETCH_MS * CLK_KHZ;
    localparam int TICK_PS = 31250;
    localparam int TICKS_MIN = CLK_PERIOD_PS / TICK_PS;
    localparam int TICK_REM_PS = CLK_PERIOD_PS - TICKS_MIN * TICK_PS;
    // ==========================================
    // carriers
    typedef struct packed {
        logic as_n;
        logic [1:0] ds_n;
        logic write_n;
        logic dtack_n;
        logic berr_n;
        logic retry_n;
        logic iack_n;
        logic acfail_n;
        logic local_bus_timeout;
        logic [3:0] br_n;
        logic bbsy_n;
        logic [7:1] irq_n;
    } bcr_vme_ctl_s;
    typedef struct packed {
        logic pas_n;
        logic ds_n;
        logic wr_n;
        logic ack_n;
        logic err_n;
    } bcr_vsb_ctl_s;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [5:0] am;
        logic lword_n;
    } bcr_vme_snap_s;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0] space;
        logic [1:0] siz;
        logic [1:0] asack_n;
        logic lock_n;
        logic cache_n;
        logic addr_err;
    } bcr_vsb_snap_s;
    typedef struct packed {
        logic [7:0] base;
        logic disp_vsb;
        logic [2:0] mode_stat;
        logic rrs;
        logic berr_stop;
        logic iack_stop;
        logic stop_state;
        logic [2:0] irq_level;
        logic [7:0] irq_vector;
        logic irq_pending;
    } bcr_sw_s;
    typedef enum logic [1:0] {
        BCR_IDLE = 2'b00,
        BCR_SEL = 2'b01,
        BCR_ACK = 2'b11,
        BCR_DONE = 2'b10
    } bcr_slave_e;
endpackage

// File: verilog/bcr_bus_capture_bank.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: 256-byte A16 window, base from rotary switches
// RULE2: sixteen 16-bit registers at even offsets
// RULE3: answer interrupt acknowledge for own level
// RULE4: data/address low and high words per bus
// RULE5: address bit0 zero, or lword in D64
// RULE6: vme status A layout, AS/ACFAIL stretched
// RULE7: vme status B layout, stop in bit15
// RULE8: burst counter bus chosen by bit10
// RULE9: clear on AS edge, count DS edges
// RULE10: saturate to zero past 255 unless free-run
// RULE11: own register cycles never touch counters
// RULE12: burst count in low eight bits
// RULE13: duration counter cleared, counts while AS held
// RULE14: count steps of 31.25 ns
// RULE15: duration stops after FFF, reads zero
// RULE16: duration bit12 mirrors counter source select
// RULE17: duration bits13-15 arbitration and stop status
// RULE18: vsb status A layout, PAS/ACFAIL stretched
// RULE19: control bits 3-0 RO, 7-4 RW, 15-8 WO
// RULE20: control bit0 returns display switch
// RULE21: display bit 0 VME, 1 VSB
// RULE22: software sets bit10 to choose source
// RULE23: writes to read-only bits acknowledged, ignored
module bcr_bus_capture_bank import bcr_pkg::*; #(
    parameter int unsigned STRETCH_CYCLES = STRETCH_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // vme pins
    input wire bcr_vme_ctl_s vme_ctl,
    input wire bcr_vme_snap_s vme_bus,
    output logic [15:0] vme_d_o,
    output logic vme_d_oe_n,
    output logic vme_dtack_o,
    output logic vme_dtack_oe_n,
    output logic iack_done,
    // vsb pins
    input wire bcr_vsb_ctl_s vsb_ctl,
    input wire bcr_vsb_snap_s vsb_bus,
    // switches, jumpers and board state
    input wire bcr_sw_s sw,
    // commands to the rest of the board
    output logic [3:0] ctl_rw,
    output logic [1:0] mode_cmd,
    output logic sreset_req,
    output logic [3:0] dtack_delay
);
    localparam int PW = $bits(bcr_vme_ctl_s) + $bits(bcr_vsb_ctl_s) + $bits(bcr_sw_s);
    localparam int SW_W = $clog2(STRETCH_CYCLES + 1);

    function automatic logic own_window(input logic [5:0] am, input logic [15:0] a, input logic [7:0] base);
        own_window = (am == AM_SHORT_SUPER || am == AM_SHORT_USER) && a[15:8] == base; // RULE1
    endfunction

    // ==========================================
    // pin synchronisers, change taken once stages 2 and 3 agree
    logic [PW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, prv_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            flt_ff <= '1;
            prv_ff <= '1;
        end else begin
            s1_ff <= {vme_ctl, vsb_ctl, sw};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            flt_ff <= (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
            prv_ff <= flt_ff;
        end
    end
    bcr_vme_ctl_s vc, vp;
    bcr_vsb_ctl_s bc, bp;
    bcr_sw_s swf;
    assign {vc, bc, swf} = flt_ff;
    assign {vp, bp} = prv_ff[PW-1:$bits(bcr_sw_s)];

    logic as_fall, as_rise, vds_fall, pas_fall, pas_rise, bds_fall;
    assign as_fall = vp.as_n & ~vc.as_n;
    assign as_rise = ~vp.as_n & vc.as_n;
    assign vds_fall = &vp.ds_n & ~&vc.ds_n;
    assign pas_fall = bp.pas_n & ~bc.pas_n;
    assign pas_rise = ~bp.pas_n & bc.pas_n;
    assign bds_fall = bp.ds_n & ~bc.ds_n;

    // ==========================================
    // cycle ownership; bus lines are stable while the strobes are held
    logic own_hit, iack_hit;
    logic own_ff, vcyc_ff, bcyc_ff;
    assign own_hit = vc.iack_n && own_window(vme_bus.am, vme_bus.addr[15:0], swf.base);
    assign iack_hit = !vc.iack_n && swf.irq_pending && vme_bus.addr[3:1] == swf.irq_level; // RULE3
    always_ff @(posedge clk) begin
        if (srst) begin
            own_ff <= 1'b0;
            vcyc_ff <= 1'b0;
        end else if (as_fall) begin
            own_ff <= own_hit || iack_hit;
            vcyc_ff <= !(own_hit || iack_hit); // RULE11
        end else if (as_rise) begin
            own_ff <= 1'b0;
            vcyc_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            bcyc_ff <= 1'b0;
        end else if (pas_fall) begin
            bcyc_ff <= 1'b1;
        end else if (pas_rise) begin
            bcyc_ff <= 1'b0;
        end
    end

    // ==========================================
    // vme capture
    logic [31:0] vaddr_ff, vdata_ff;
    logic [5:0] vam_ff;
    logic vlw_ff, vds0_ff, vds1_ff, vwr_ff, vdtk_ff, vberr_ff, vrty_ff, vlbto_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            vaddr_ff <= '0;
            vam_ff <= '0;
            vlw_ff <= 1'b0;
            vwr_ff <= 1'b0;
        end else if (as_fall && !(own_hit || iack_hit)) begin
            vaddr_ff <= vme_bus.addr; // RULE4
            vam_ff <= vme_bus.am;
            vlw_ff <= !vme_bus.lword_n;
            vwr_ff <= !vc.write_n;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            vdata_ff <= '0;
            vds0_ff <= 1'b0;
            vds1_ff <= 1'b0;
        end else if (vcyc_ff && vds_fall) begin
            vdata_ff <= vme_bus.data; // RULE4
            vds0_ff <= !vc.ds_n[0];
            vds1_ff <= !vc.ds_n[1];
        end
    end
    // handshake flags: cleared at a monitored address edge, set when seen while that cycle's AS is still held
    always_ff @(posedge clk) begin
        if (srst || (as_fall && !(own_hit || iack_hit))) begin
            vdtk_ff <= 1'b0;
            vberr_ff <= 1'b0;
            vrty_ff <= 1'b0;
            vlbto_ff <= 1'b0;
        end else if (vcyc_ff) begin
            vdtk_ff <= vdtk_ff | !vc.dtack_n;
            vberr_ff <= vberr_ff | !vc.berr_n;
            vrty_ff <= vrty_ff | !vc.retry_n;
            vlbto_ff <= vlbto_ff | vc.local_bus_timeout;
        end
    end

    // ==========================================
    // vsb capture
    bcr_vsb_snap_s bsnap_ff;
    logic bwr_ff, bds_ff, back_ff, berr_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            bsnap_ff <= '0;
            bwr_ff <= 1'b0;
        end else if (pas_fall) begin
            bsnap_ff <= vsb_bus; // RULE4
            bwr_ff <= !bc.wr_n;
        end else if (bcyc_ff && bds_fall) begin
            bsnap_ff.data <= vsb_bus.data;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || pas_fall) begin
            bds_ff <= 1'b0;
            back_ff <= 1'b0;
            berr_ff <= 1'b0;
        end else if (bcyc_ff) begin
            bds_ff <= bds_ff | !bc.ds_n;
            back_ff <= back_ff | !bc.ack_n;
            berr_ff <= berr_ff | !bc.err_n;
        end
    end

    // ==========================================
    // 350 ms stretchers: vme AS, ACFAIL, BR0, vsb PAS
    logic [3:0] st_in, st_on;
    logic [SW_W-1:0] st_cnt_ff [4];
    assign st_in = {!bc.pas_n, !vc.br_n[0], !vc.acfail_n, !vc.as_n};
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (srst) begin
                st_cnt_ff[i] <= '0;
            end else if (st_in[i]) begin
                st_cnt_ff[i] <= SW_W'(STRETCH_CYCLES); // RULE6 RULE18
            end else if (st_cnt_ff[i] != '0) begin
                st_cnt_ff[i] <= st_cnt_ff[i] - 1'b1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            st_on[i] = st_cnt_ff[i] != '0;
        end
    end

    // ==========================================
    // control word
    logic src_sel_ff;
    logic wr_strobe;
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_rw <= CTL_RW_RST;
            src_sel_ff <= 1'b0;
            dtack_delay <= CTL_DELAY_RST;
            mode_cmd <= 2'h0;
            sreset_req <= 1'b0;
        end else begin
            mode_cmd <= 2'h0;
            sreset_req <= 1'b0;
            if (wr_strobe) begin
                ctl_rw <= vme_bus.data[CTL_RW_LSB+:4]; // RULE19
                src_sel_ff <= vme_bus.data[CTL_SRC_SEL_BIT]; // RULE8 RULE22
                dtack_delay <= vme_bus.data[CTL_DELAY_LSB+:4];
                mode_cmd <= vme_bus.data[CTL_MODE_LSB+:2];
                sreset_req <= vme_bus.data[CTL_SRESET_BIT];
            end
        end
    end

    // ==========================================
    // burst and duration counters on the selected bus
    logic cnt_start, cnt_ds, cnt_run;
    logic [8:0] burst_ff;
    logic [12:0] time_ff;
    logic [15:0] acc_ff;
    logic [15:0] acc_sum;
    assign cnt_start = src_sel_ff ? pas_fall : (as_fall && !(own_hit || iack_hit)); // RULE11
    assign cnt_ds = src_sel_ff ? (bcyc_ff && bds_fall) : (vcyc_ff && vds_fall);
    assign cnt_run = src_sel_ff ? (bcyc_ff && !bc.pas_n) : (vcyc_ff && !vc.as_n);
    assign acc_sum = acc_ff + 16'(TICK_REM_PS);
    always_ff @(posedge clk) begin
        if (srst || cnt_start) begin
            burst_ff <= '0; // RULE9
        end else if (cnt_ds) begin
            if (ctl_rw[CTL_FREE_RUN_BIT-CTL_RW_LSB]) begin
                burst_ff <= {1'b0, burst_ff[7:0] + 8'h01}; // RULE10
            end else if (!burst_ff[8]) begin
                burst_ff <= burst_ff + 9'h001; // RULE10
            end
        end
    end
    // 100 ns clock against 31.25 ns steps: 3 or 4 steps a clock, remainder carried
    always_ff @(posedge clk) begin
        if (srst || cnt_start) begin
            time_ff <= '0; // RULE13
            acc_ff <= '0;
        end else if (cnt_run && !time_ff[12]) begin
            if (acc_sum >= 16'(TICK_PS)) begin
                acc_ff <= acc_sum - 16'(TICK_PS); // RULE14
                time_ff <= time_ff + 13'(TICKS_MIN + 1);
            end else begin
                acc_ff <= acc_sum;
                time_ff <= time_ff + 13'(TICKS_MIN); // RULE14
            end
        end
    end
    logic [11:0] time_show;
    assign time_show = time_ff[12] ? 12'h000 : time_ff[11:0]; // RULE15

    // ==========================================
    // register read mux
    logic [15:0] rd_data;
    logic d64_on;
    assign d64_on = ctl_rw[0] && ctl_rw[1];
    always_comb begin
        rd_data = 16'h0000;
        if (vme_bus.addr[7:5] == 3'h0) begin // RULE2
            case ({vme_bus.addr[7:1], 1'b0})
                OFS_VME_DATA_LOW: rd_data = vdata_ff[15:0];
                OFS_VME_DATA_HIGH: rd_data = vdata_ff[31:16];
                OFS_VME_ADDRESS_LOW: rd_data = {vaddr_ff[15:1], d64_on & vlw_ff}; // RULE5
                OFS_VME_ADDRESS_HIGH: rd_data = vaddr_ff[31:16];
                OFS_VME_STATUS_A: rd_data = {st_on[1], vlbto_ff, vrty_ff, vberr_ff, vdtk_ff, vwr_ff,
                    vds1_ff, vds0_ff, st_on[0], vlw_ff, vam_ff}; // RULE6
                OFS_VME_STATUS_B: rd_data = {swf.stop_state, 2'b00, ~vc.irq_n, !vc.iack_n, !vc.bbsy_n,
                    ~vc.br_n[3:1], st_on[2]}; // RULE7
                OFS_BURST_COUNT: rd_data = {8'h00, burst_ff[8] ? 8'h00 : burst_ff[7:0]}; // RULE12
                OFS_CYCLE_TIME: rd_data = {swf.iack_stop, swf.berr_stop, swf.rrs, src_sel_ff,
                    time_show}; // RULE16 RULE17
                OFS_VSB_DATA_LOW: rd_data = bsnap_ff.data[15:0];
                OFS_VSB_DATA_HIGH: rd_data = bsnap_ff.data[31:16];
                OFS_VSB_ADDRESS_LOW: rd_data = bsnap_ff.addr[15:0];
                OFS_VSB_ADDRESS_HIGH: rd_data = bsnap_ff.addr[31:16];
                OFS_VSB_STATUS_A: rd_data = {st_on[1], bsnap_ff.addr_err, !bsnap_ff.cache_n, berr_ff,
                    back_ff, bwr_ff, 1'b0, bds_ff, st_on[3], !bsnap_ff.lock_n, ~bsnap_ff.asack_n,
                    bsnap_ff.siz, bsnap_ff.space}; // RULE18
                OFS_CONTROL_STATUS: rd_data = {8'h00, ctl_rw, swf.mode_stat, swf.disp_vsb}; // RULE19 RULE20 RULE21
                OFS_JUMPER_READBACK: rd_data = {4'h0, swf.irq_pending, swf.irq_level, swf.irq_vector};
                default: rd_data = 16'h0000;
            endcase
        end
    end

    // ==========================================
    // a16 slave and interrupt acknowledge answer
    bcr_slave_e st_ff;
    logic iack_cyc_ff;
    assign wr_strobe = st_ff == BCR_SEL && !iack_cyc_ff && ~&vc.ds_n && !vc.write_n
        && vme_bus.addr[7:0] == OFS_CONTROL_STATUS; // RULE23
    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= BCR_IDLE;
            iack_cyc_ff <= 1'b0;
            vme_d_o <= 16'h0000;
            vme_d_oe_n <= 1'b1;
            vme_dtack_o <= 1'b0;
            vme_dtack_oe_n <= 1'b1;
            iack_done <= 1'b0;
        end else begin
            iack_done <= 1'b0;
            case (st_ff)
                BCR_IDLE: begin
                    if (as_fall && (own_hit || iack_hit)) begin
                        st_ff <= BCR_SEL;
                        iack_cyc_ff <= iack_hit;
                    end
                end
                BCR_SEL: begin
                    if (vc.as_n) begin
                        st_ff <= BCR_IDLE;
                    end else if (~&vc.ds_n) begin
                        st_ff <= BCR_ACK;
                        vme_dtack_oe_n <= 1'b0;
                        if (iack_cyc_ff) begin
                            vme_d_o <= {8'h00, swf.irq_vector}; // RULE3
                            vme_d_oe_n <= 1'b0;
                            iack_done <= 1'b1;
                        end else if (!vc.write_n) begin
                            vme_d_oe_n <= 1'b1; // RULE23
                        end else begin
                            vme_d_o <= rd_data;
                            vme_d_oe_n <= 1'b0;
                        end
                    end
                end
                BCR_ACK: begin
                    if (&vc.ds_n) begin
                        st_ff <= BCR_DONE;
                        vme_dtack_oe_n <= 1'b1;
                        vme_d_oe_n <= 1'b1;
                    end
                end
                BCR_DONE: begin
                    // block transfers may repeat the data strobe under one address strobe
                    if (vc.as_n) begin
                        st_ff <= BCR_IDLE;
                    end else if (~&vc.ds_n) begin
                        st_ff <= BCR_SEL;
                    end
                end
                default: st_ff <= BCR_IDLE;
            endcase
        end
    end

    // ==========================================
    // checks
    bc_own_a: assert property (@(posedge clk) disable iff (srst) as_fall && own_hit |=> own_ff && !vcyc_ff) // RULE11
        else $error("own cycle marked as monitored");
    bc_win_a: assert property (@(posedge clk) disable iff (srst)
        as_fall && vc.iack_n && vme_bus.addr[15:8] != swf.base |=> st_ff == BCR_IDLE) // RULE1
        else $error("foreign address selected");
    bc_clr_a: assert property (@(posedge clk) disable iff (srst) cnt_start |=> burst_ff == 9'h000 && time_ff == 13'h0000) // RULE9
        else $error("counters not cleared at cycle start");
    bc_inc_a: assert property (@(posedge clk) disable iff (srst)
        cnt_ds && !cnt_start && burst_ff < 9'h0FF |=> burst_ff == $past(burst_ff) + 9'h001) // RULE9
        else $error("burst count missed a strobe");
    bc_sat_a: assert property (@(posedge clk) disable iff (srst)
        !ctl_rw[3] && burst_ff[8] && !cnt_start |=> burst_ff[8]) // RULE10
        else $error("burst saturation lost");
    bc_stop_a: assert property (@(posedge clk) disable iff (srst) time_ff[12] && !cnt_start |=> $stable(time_ff)) // RULE15
        else $error("duration counter ran past stop");
    bc_step_a: assert property (@(posedge clk) disable iff (srst)
        cnt_run && !cnt_start && !time_ff[12] |=> time_ff - $past(time_ff) inside {13'd3, 13'd4}) // RULE14
        else $error("duration step wrong");
    bc_dtk_a: assert property (@(posedge clk) disable iff (srst) st_ff == BCR_SEL && ~&vc.ds_n && !vc.as_n
        |=> !vme_dtack_oe_n ##1 !vme_dtack_oe_n || &vc.ds_n) // RULE2
        else $error("no acknowledge for selected access");
    bc_ivec_a: assert property (@(posedge clk) disable iff (srst) iack_done |-> vme_d_o[7:0] == swf.irq_vector && !vme_d_oe_n) // RULE3
        else $error("wrong vector on acknowledge");
    bc_ro_a: assert property (@(posedge clk) disable iff (srst) !wr_strobe |=> $stable(src_sel_ff)) // RULE23
        else $error("control changed without write");
    bc_stretch_a: assert property (@(posedge clk) disable iff (srst) st_in[0] |=> st_on[0] [*8]) // RULE6
        else $error("address strobe not stretched");
    bc_own_c: cover property (@(posedge clk) disable iff (srst) st_ff == BCR_ACK && !iack_cyc_ff);
    bc_iack_c: cover property (@(posedge clk) disable iff (srst) iack_done);
    bc_sat_c: cover property (@(posedge clk) disable iff (srst) burst_ff[8]);
    bc_vsb_c: cover property (@(posedge clk) disable iff (srst) src_sel_ff && cnt_ds);
endmodule

// File: verif/bcr_vme_master.sv
`timescale 1ns/1ps
// ====
// vme master partner
module bcr_vme_master import bcr_pkg::*; (
    // clock
    input wire logic clk,
    // driven lines
    output bcr_vme_ctl_s ctl,
    output bcr_vme_snap_s bus,
    // slave answer
    input wire logic [15:0] d_o,
    input wire logic d_oe_n,
    input wire logic dtack_oe_n
);
    int held;
    initial begin
        ctl = '1;
        ctl.local_bus_timeout = 1'b0;
        bus = '0;
    end
    // ====
    // own-register cycle, returns x when never acked
    task automatic cyc(input logic ia, input logic wr, input logic [15:0] a, input logic [15:0] wd,
                       output logic [15:0] rd);
        int n;
        #1 bus.addr = {16'h0000, a};
        bus.data = {16'h0000, wd};
        bus.am = AM_SHORT_SUPER;
        ctl.iack_n = !ia;
        ctl.write_n = !wr;
        repeat (5) @(posedge clk);
        #1 ctl.as_n = 1'b0;
        ctl.ds_n = 2'b00;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dtack_oe_n !== 1'b0 && n < 40);
        rd = (dtack_oe_n !== 1'b0) ? 'x : (wr ? 16'h0000 : ((d_oe_n === 1'b0) ? d_o : 'x));
        #1 ctl.as_n = 1'b1;
        ctl.ds_n = 2'b11;
        ctl.iack_n = 1'b1;
        // released data lines show the inverse, never a stale match
        bus.data = ~bus.data;
        n = 0;
        while (dtack_oe_n !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask
    // ====
    // foreign write answered elsewhere, k data strobes
    task automatic fgn(input logic [31:0] a, input logic [31:0] d, input int k);
        #1 bus.addr = a;
        bus.data = d;
        bus.am = 6'h09;
        bus.lword_n = 1'b0;
        ctl.write_n = 1'b0;
        held = 4 + 10 * k;
        repeat (5) @(posedge clk);
        #1 ctl.as_n = 1'b0;
        repeat (2) @(posedge clk);
        repeat (k) begin
            #1 ctl.ds_n = 2'b00;
            repeat (5) @(posedge clk);
            #1 ctl.ds_n = 2'b11;
            repeat (5) @(posedge clk);
        end
        repeat (2) @(posedge clk);
        #1 ctl.as_n = 1'b1;
        bus.data = ~d;
        repeat (8) @(posedge clk);
    endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top import bcr_pkg::*;;
    logic clk;
    logic srst;
    bcr_vme_ctl_s vme_ctl;
    bcr_vme_snap_s vme_bus;
    bcr_vsb_ctl_s vsb_ctl;
    bcr_vsb_snap_s vsb_bus;
    bcr_sw_s sw;
    logic [15:0] d_o;
    logic d_oe_n;
    logic dt_oe_n;
    logic [3:0] ctl_rw;
    logic [3:0] dly;
    logic [15:0] v;
    int mismatches;
    int check_count;
    int e;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    bcr_vme_master m (.clk(clk), .ctl(vme_ctl), .bus(vme_bus), .d_o(d_o), .d_oe_n(d_oe_n),
                      .dtack_oe_n(dt_oe_n));
    bcr_bus_capture_bank #(.STRETCH_CYCLES(20)) dut (.clk(clk), .srst(srst), .vme_ctl(vme_ctl),
        .vme_bus(vme_bus), .vme_d_o(d_o), .vme_d_oe_n(d_oe_n), .vme_dtack_o(), .vme_dtack_oe_n(dt_oe_n),
        .iack_done(), .vsb_ctl(vsb_ctl), .vsb_bus(vsb_bus), .sw(sw), .ctl_rw(ctl_rw), .mode_cmd(),
        .sreset_req(), .dtack_delay(dly));
    // ====
    // tasks
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic rdc(input logic [7:0] o, input logic [15:0] x, input string nm, input logic [15:0] mk = 16'hFFFF);
        m.cyc(1'b0, 1'b0, {sw.base, o}, 16'h0000, v);
        chk(nm, v & mk, x & mk);
    endtask
    task automatic wr(input logic [7:0] o, input logic [15:0] d);
        m.cyc(1'b0, 1'b1, {sw.base, o}, d, v);
        chk("write ack", v, 16'h0000);
    endtask
    task automatic vsb(input int k);
        repeat (5) @(posedge clk);
        #1 vsb_ctl.pas_n = 1'b0;
        repeat (k) begin
            repeat (5) @(posedge clk);
            #1 vsb_ctl.ds_n = 1'b0;
            repeat (5) @(posedge clk);
            #1 vsb_ctl.ds_n = 1'b1;
        end
        repeat (5) @(posedge clk);
        #1 vsb_ctl.pas_n = 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ====
    // watchdog, run needs about 1 ms
    initial begin
        #5000000;
        mismatches++;
        results();
    end
    // ====
    // tests
    initial begin
        srst = 1'b1;
        vsb_ctl = '1;
        vsb_bus = '0;
        vsb_bus.addr = 32'h89AB_CDEF;
        vsb_bus.data = 32'h0F1E_2D3C;
        sw = '0;
        sw.base = 8'hC3;
        sw.disp_vsb = 1'b1;
        sw.mode_stat = 3'b010;
        sw.rrs = 1'b1;
        sw.iack_stop = 1'b1;
        sw.stop_state = 1'b1;
        sw.irq_level = 3'd3;
        sw.irq_vector = 8'h5A;
        sw.irq_pending = 1'b1;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        rdc(OFS_CONTROL_STATUS, 16'h0005, "ctl reset");
        m.cyc(1'b0, 1'b0, {sw.base, OFS_CYCLE_TIME}, 16'h0000, v);
        chk("time status", {12'h000, v[15:12]}, 16'h000A);
        wr(OFS_CONTROL_STATUS, 16'hA1A0);
        chk("ctl rw", {8'h00, ctl_rw, dly}, 16'h00AA);
        rdc(OFS_CONTROL_STATUS, 16'h00A5, "ctl back");
        $display("test control done");
        m.fgn(32'h1234_5679, 32'hCAFE_BABE, 3);
        rdc(OFS_VME_DATA_LOW, 16'hBABE, "data low");
        rdc(OFS_VME_DATA_HIGH, 16'hCAFE, "data high");
        rdc(OFS_VME_ADDRESS_LOW, 16'h5678, "addr low");
        rdc(OFS_VME_ADDRESS_HIGH, 16'h1234, "addr high");
        rdc(OFS_VME_STATUS_A, 16'h07C9, "stat a");
        chk("stat a am as", {8'h00, v[7], 1'b0, v[5:0]}, 16'h0089);
        rdc(OFS_VME_STATUS_B, 16'h8000, "stat b");
        chk("stat b top", {13'h0000, v[15:13]}, 16'h0004);
        repeat (2) begin
            rdc(OFS_BURST_COUNT, 16'h0003, "burst", 16'h00FF);
            chk("burst low", {8'h00, v[7:0]}, 16'h0003);
        end
        rdc(OFS_CYCLE_TIME, 16'hA000, "time", 16'hF000);
        e = m.held * 16 / 5;
        chk("time near", {15'h0000, v[11:0] + 4 >= e && v[11:0] <= e + 4}, 16'h0001);
        wr(OFS_VME_DATA_LOW, 16'h1111);
        rdc(OFS_VME_DATA_LOW, 16'hBABE, "ro write");
        rdc(8'h40, 16'h0000, "unmapped");
        m.cyc(1'b0, 1'b0, {8'hC2, OFS_CONTROL_STATUS}, 16'h0000, v);
        chk("other base", v, 'x);
        $display("test capture done");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CONTROL_STATUS, (i == 2) ? 16'h0080 : 16'h0000);
            m.fgn(32'h0000_0100, 32'h0000_0001, (i == 0) ? 255 : 257);
            rdc(OFS_BURST_COUNT, (i == 0) ? 16'h00FF : {15'h0000, i == 2}, "burst", 16'h00FF);
            chk("burst wrap", {8'h00, v[7:0]}, (i == 0) ? 16'h00FF : {15'h0000, i == 2});
            rdc(OFS_CYCLE_TIME, 16'hA000, "time", 16'hF000);
            chk("time over", {4'h0, v[11:0]}, 16'h0000);
        end
        $display("test counters done");
        wr(OFS_CONTROL_STATUS, 16'h0400);
        vsb(2);
        rdc(OFS_BURST_COUNT, 16'h0002, "burst", 16'h00FF);
        chk("vsb burst", {8'h00, v[7:0]}, 16'h0002);
        rdc(OFS_CYCLE_TIME, 16'hB000, "time", 16'hF000);
        chk("time src", {15'h0000, v[12]}, 16'h0001);
        rdc(OFS_VSB_DATA_LOW, 16'h2D3C, "vsb dl");
        rdc(OFS_VSB_DATA_HIGH, 16'h0F1E, "vsb dh");
        rdc(OFS_VSB_ADDRESS_LOW, 16'hCDEF, "vsb al");
        rdc(OFS_VSB_ADDRESS_HIGH, 16'h89AB, "vsb ah");
        rdc(OFS_VSB_STATUS_A, 16'h2170, "vsb sa");
        m.cyc(1'b1, 1'b0, 16'h0006, 16'h0000, v);
        chk("iack vector", v, 16'h005A);
        for (int i = 0; i < 16; i++) begin
            m.cyc(1'b0, 1'b0, {sw.base, 8'(2 * i)}, 16'h0000, v);
            chk("reachable", {15'h0000, ^v[7:0] !== 1'bx}, 16'h0001);
        end
        $display("test vsb iack done");
        results();
    end
endmodule
